// >>> core/spcu_top.sv
// The APB slave port is this design's own decision.
`default_nettype none
// Notes on behaviour
// - control at 98h: mode hi, mode lo, amen, rxen, tx9, rx9, tx, rx done
// - bit 7 is framing error when frame_err_select set, else mode high bit
// - invalid stop bit sets framing error; only software clears it
// - mode pair selects shift, 8-bit variable, 9-bit fixed, 9-bit variable
// - modes 2/3 with amen: receive flag needs ninth bit one and address match
// - mode 1 with amen: receive flag needs valid stop bit and address match
// - reception only while rx_enable is set
// - modes 2/3 send tx_ninth_bit as ninth bit; unused in mode 0
// - ninth bit stored in modes 2/3; stop bit in mode 1 when amen clear
// - tx flag at end of 8th bit in mode 0, else at stop bit start
// - rx flag at end of 8th bit in mode 0, else mid stop bit
// - broadcast address is own OR mask; zero bits are don't care
// - given address is own under mask; only unmasked bits must match
module spcu_top
	import spcu_pkg::*;
(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [spcu_pkg::SPCU_ADDR_W-1:0] paddr,
	input  wire logic [31:0]                  pwdata,
	output var  logic [31:0]                  prdata,
	output var  logic                         pready,
	output var  logic                         pslverr,
	input  wire logic                         rxd_in,
	output var  logic                         rxd_out,
	output var  logic                         rxd_oe,
	output var  logic                         txd,
	output var  logic                         irq
);
	import spcu_pkg::*;

	default clocking ast_clk @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ======================================================
	// register bus
	logic                acc;
	logic                wr_ok;
	logic                ctl_wr;
	logic [31:0]         rd_data;
	logic                rd_hit;
	logic                mode_hi, mode_lo, amen, rx_en, tx9, rx9;
	logic                tx_done, rx_done, fe, fe_sel, baud_dbl;
	logic [7:0]          own_addr, addr_mask, rx_buf;
	logic [15:0]         baud_div;
	logic [IRQ_W-1:0]    irq_status, irq_mask;
	spcu_mode_type       mode;

	assign mode   = spcu_mode_type'({mode_hi, mode_lo});
	assign acc    = psel & penable;
	assign wr_ok  = acc & pready & pwrite;
	assign ctl_wr = wr_ok & (paddr == SPCU_OFF_CONTROL);

	always_comb
	begin
		rd_hit  = 1'b1;
		rd_data = 32'h0;
		unique case (paddr)
			SPCU_OFF_CONTROL:  rd_data[7:0] = {fe_sel ? fe : mode_hi,
				mode_lo, amen, rx_en, tx9, rx9, tx_done, rx_done};
			SPCU_OFF_DATA:     rd_data[7:0] = rx_buf;
			SPCU_OFF_POWER:    rd_data[7:0] = {baud_dbl, fe_sel, 6'h0};
			SPCU_OFF_OWN_ADDR: rd_data[7:0] = own_addr;
			SPCU_OFF_ADDR_MSK: rd_data[7:0] = addr_mask;
			SPCU_OFF_BAUD:     rd_data[15:0] = baud_div;
			SPCU_OFF_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_status;
			SPCU_OFF_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask;
			default:           rd_hit = 1'b0;
		endcase
	end

	// one wait state; data and error stand with pready
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= acc & ~pready;
			pslverr <= acc & ~pready & ~rd_hit;
			if (acc & ~pready & ~pwrite)
				prdata <= rd_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{baud_dbl, fe_sel} <= PWR_RESET[7:6];
			own_addr  <= ADDR_RESET;
			addr_mask <= ADDR_RESET;
			baud_div  <= BAUD_RESET;
			irq_mask  <= IRQ_RESET;
		end
		else if (wr_ok)
		begin
			unique case (paddr)
				SPCU_OFF_POWER:
				begin
					baud_dbl <= pwdata[PWR_BAUD_DBL];
					fe_sel   <= pwdata[PWR_FE_SEL];
				end
				SPCU_OFF_OWN_ADDR: own_addr  <= pwdata[7:0];
				SPCU_OFF_ADDR_MSK: addr_mask <= pwdata[7:0];
				SPCU_OFF_BAUD:     baud_div  <= pwdata[15:0];
				SPCU_OFF_IRQ_MASK: irq_mask  <= pwdata[IRQ_W-1:0];
				default:           ;
			endcase
		end
	end

	// ======================================================
	// bit timing
	logic [15:0]         bit_cyc;
	logic [15:0]         half_cyc;
	always_comb
	begin
		unique case (mode)
			MODE_SHIFT: bit_cyc = MODE0_BIT_CYC;
			MODE_9FIX:  bit_cyc = baud_dbl ? MODE2_BIT_FAST
				: MODE2_BIT_SLOW;
			default:    bit_cyc = baud_div;
		endcase
	end
	assign half_cyc = bit_cyc >> 1;

	// ======================================================
	// transmitter
	spcu_frame_type      tx_state;
	logic [15:0]         tx_cnt;
	logic [2:0]          tx_bit;
	logic [7:0]          tx_sh;
	logic                tx_go, tx_end, tx_set, nine_bit;

	assign nine_bit = mode_hi;
	assign tx_go  = wr_ok & (paddr == SPCU_OFF_DATA)
		& (tx_state == FR_IDLE);
	assign tx_end = (tx_state != FR_IDLE) & (tx_cnt == 16'h0);
	// nine-bit frames flag after the ninth bit, not after the eighth
	assign tx_set = tx_end & ((tx_state == FR_NINTH)
		| (tx_state == FR_DATA & tx_bit == LAST_DATA_BIT
		& ~nine_bit));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_state <= FR_IDLE;
			tx_cnt   <= 16'h0;
			tx_bit   <= 3'h0;
			tx_sh    <= 8'h0;
		end
		else if (tx_go)
		begin
			tx_sh    <= pwdata[7:0];
			tx_bit   <= 3'h0;
			tx_cnt   <= bit_cyc - 16'h1;
			tx_state <= (mode == MODE_SHIFT) ? FR_DATA : FR_START;
		end
		else if (tx_state != FR_IDLE)
		begin
			tx_cnt <= tx_end ? bit_cyc - 16'h1 : tx_cnt - 16'h1;
			if (tx_end)
			begin
				unique case (tx_state)
					FR_START: tx_state <= FR_DATA;
					FR_DATA:
					begin
						tx_sh  <= tx_sh >> 1;
						tx_bit <= tx_bit + 3'h1;
						if (tx_bit == LAST_DATA_BIT)
							tx_state <= (mode == MODE_SHIFT) ? FR_IDLE
								: nine_bit ? FR_NINTH : FR_STOP;
					end
					FR_NINTH: tx_state <= FR_STOP;
					default:  tx_state <= FR_IDLE;
				endcase
			end
		end
	end

	// ======================================================
	// receiver
	logic                rxd_meta, rxd_sync, rxd_prev;
	spcu_frame_type      rx_state;
	logic [15:0]         rx_cnt;
	logic [2:0]          rx_bit;
	logic [7:0]          rx_sh;
	logic                rx_nine_tmp, rx_end, rx_sample, rx_frame_end;
	logic                rx_accept, addr_match, fe_set, rx_set;
	logic [7:0]          bcast;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			rxd_prev <= 1'b1;
		end
		else
		begin
			rxd_meta <= rxd_in;
			rxd_sync <= rxd_meta;
			rxd_prev <= rxd_sync;
		end
	end

	assign bcast      = own_addr | addr_mask;
	assign addr_match = (((rx_sh ^ own_addr) & addr_mask) == 8'h0)
		| ((rx_sh & bcast) == bcast);
	assign rx_end    = (rx_state != FR_IDLE) & (rx_cnt == 16'h0);
	assign rx_sample = (rx_state == FR_DATA) & (rx_cnt ==
		((mode == MODE_SHIFT) ? half_cyc - 16'h1 : 16'h0));
	assign rx_frame_end = rx_end & ((rx_state == FR_STOP)
		| (mode == MODE_SHIFT & rx_state == FR_DATA
		& rx_bit == LAST_DATA_BIT));
	// amen is assumed clear in mode 0, so it is not looked at there
	assign rx_accept = rx_frame_end & ((mode == MODE_SHIFT) | ~amen
		| (mode == MODE_8BIT ? rxd_sync & addr_match
		: rx_nine_tmp & addr_match));
	assign rx_set = rx_accept;
	assign fe_set = rx_frame_end & (mode != MODE_SHIFT) & ~rxd_sync;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_state    <= FR_IDLE;
			rx_cnt      <= 16'h0;
			rx_bit      <= 3'h0;
			rx_sh       <= 8'h0;
			rx_nine_tmp <= 1'b0;
		end
		else if (!rx_en)
			rx_state <= FR_IDLE;
		else if (rx_state == FR_IDLE)
		begin
			rx_bit <= 3'h0;
			if (mode == MODE_SHIFT && !rx_done && tx_state == FR_IDLE)
			begin
				rx_cnt   <= bit_cyc - 16'h1;
				rx_state <= FR_DATA;
			end
			else if (mode != MODE_SHIFT && rxd_prev && !rxd_sync)
			begin
				rx_cnt   <= half_cyc - 16'h1;
				rx_state <= FR_START;
			end
		end
		else
		begin
			rx_cnt <= rx_end ? bit_cyc - 16'h1 : rx_cnt - 16'h1;
			if (rx_sample)
				rx_sh <= {rxd_sync, rx_sh[7:1]};
			if (rx_end)
			begin
				unique case (rx_state)
					// glitch shorter than half a bit is dropped
					FR_START: rx_state <= rxd_sync ? FR_IDLE : FR_DATA;
					FR_DATA:
					begin
						rx_bit <= rx_bit + 3'h1;
						if (rx_bit == LAST_DATA_BIT)
							rx_state <= (mode == MODE_SHIFT) ? FR_IDLE
								: nine_bit ? FR_NINTH : FR_STOP;
					end
					FR_NINTH:
					begin
						rx_nine_tmp <= rxd_sync;
						rx_state    <= FR_STOP;
					end
					default: rx_state <= FR_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rx_buf <= 8'h0;
		else if (rx_accept)
			rx_buf <= rx_sh;
	end

	// ======================================================
	// control register; hardware set wins over software write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{mode_hi, mode_lo, amen, rx_en, tx9} <= CTL_RESET[7:3];
			{rx9, tx_done, rx_done, fe} <= 4'h0;
		end
		else
		begin
			if (ctl_wr)
			begin
				if (!fe_sel)
					mode_hi <= pwdata[CTL_MODE_HI];
				mode_lo <= pwdata[CTL_MODE_LO];
				amen    <= pwdata[CTL_AMEN];
				rx_en   <= pwdata[CTL_RX_EN];
				tx9     <= pwdata[CTL_TX9];
			end
			fe <= fe_set | (ctl_wr & fe_sel ? pwdata[CTL_MODE_HI]
				: fe);
			tx_done <= tx_set | (ctl_wr ? pwdata[CTL_TX_DONE]
				: tx_done);
			rx_done <= rx_set | (ctl_wr ? pwdata[CTL_RX_DONE]
				: rx_done);
			if (rx_accept && mode[1])
				rx9 <= rx_nine_tmp;
			else if (rx_accept && mode == MODE_8BIT && !amen)
				rx9 <= rxd_sync;
			else if (ctl_wr)
				rx9 <= pwdata[CTL_RX9];
		end
	end

	// ======================================================
	// interrupt status, write one to clear
	logic [IRQ_W-1:0]    irq_ev;
	assign irq_ev = {fe_set, tx_set, rx_set};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= IRQ_RESET;
			irq <= 1'b0;
		end
		else
		begin
			irq_status <= irq_ev | (irq_status & ~((wr_ok
				& paddr == SPCU_OFF_IRQ_STAT) ? pwdata[IRQ_W-1:0]
				: IRQ_RESET));
			irq <= |(irq_status & irq_mask);
		end
	end

	// ======================================================
	// pins; mode 0 drives shift clock on txd, data on rxd
	logic                tx_line, clk_lo, sh_busy;
	assign sh_busy = (tx_state == FR_DATA) | (rx_state == FR_DATA);
	assign clk_lo  = (tx_state == FR_DATA) ? tx_cnt >= half_cyc
		: rx_cnt >= half_cyc;
	always_comb
	begin
		unique case (tx_state)
			FR_START: tx_line = 1'b0;
			FR_DATA:  tx_line = tx_sh[0];
			FR_NINTH: tx_line = tx9;
			default:  tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			txd     <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end
		else if (mode == MODE_SHIFT)
		begin
			txd     <= ~(sh_busy & clk_lo);
			rxd_out <= tx_sh[0];
			rxd_oe  <= tx_state == FR_DATA;
		end
		else
		begin
			txd     <= tx_line;
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end
	end

	// ======================================================
	// assertions
	sequence s_tx0_go;
		tx_go && mode == MODE_SHIFT;
	endsequence
	sequence s_tx2_fast_go;
		tx_go && mode == MODE_9FIX && baud_dbl;
	endsequence

	AST_TX_DONE_STOP: assert property (
		tx_state == FR_STOP && $past(tx_state) != FR_STOP |-> tx_done)
		else $error("tx flag not set at stop bit start");
	// flag lands with the edge that ends bit 8, seen one cycle later
	AST_MODE0_FRAME: assert property (
		s_tx0_go |=> tx_state == FR_DATA ##95 tx_state == FR_DATA
		##1 tx_state == FR_IDLE && tx_done)
		else $error("mode 0 frame not eight bits of twelve cycles");
	AST_MODE2_FAST: assert property (
		s_tx2_fast_go |=> tx_state == FR_START ##31 tx_state == FR_START
		##1 tx_state == FR_DATA)
		else $error("mode 2 doubled bit time is not 32 cycles");
	AST_FE_STICKY: assert property (
		fe && !ctl_wr |=> fe)
		else $error("framing error cleared without a write");
	AST_RX_OFF: assert property (
		!rx_en |=> rx_state == FR_IDLE && !rx_frame_end)
		else $error("receiver active while disabled");
	AST_ADDR_GATE: assert property (
		rx_frame_end && amen && mode[1] && !(rx_nine_tmp && addr_match)
		&& !ctl_wr |=> rx_done == $past(rx_done) && rx_buf == $past(rx_buf))
		else $error("non-address frame raised receive flag");
	AST_STOP_IN_RX9: assert property (
		rx_accept && mode == MODE_8BIT && !amen |=> rx9 == $past(rxd_sync)
		&& rx_done)
		else $error("mode 1 stop bit not stored");
	AST_FE_READ: assert property (
		acc && !pready && !pwrite && paddr == SPCU_OFF_CONTROL && fe_sel
		|=> pready && prdata[CTL_MODE_HI] == $past(fe))
		else $error("bit 7 read does not show framing error");
endmodule
`default_nettype wire

// >>> shared/spcu_pkg.sv
`default_nettype none
package spcu_pkg;
	// ======================================================
	// bus and register map
	localparam int             SPCU_ADDR_W       = 8;
	localparam logic [7:0]     SPCU_OFF_CONTROL  = 8'h98;
	localparam logic [7:0]     SPCU_OFF_DATA     = 8'h9c;
	localparam logic [7:0]     SPCU_OFF_POWER    = 8'ha0;
	localparam logic [7:0]     SPCU_OFF_OWN_ADDR = 8'ha4;
	localparam logic [7:0]     SPCU_OFF_ADDR_MSK = 8'ha8;
	localparam logic [7:0]     SPCU_OFF_BAUD     = 8'hac;
	localparam logic [7:0]     SPCU_OFF_IRQ_STAT = 8'hb0;
	localparam logic [7:0]     SPCU_OFF_IRQ_MASK = 8'hb4;
	// ======================================================
	// control, power and interrupt register fields
	localparam int             CTL_MODE_HI       = 7;
	localparam int             CTL_MODE_LO       = 6;
	localparam int             CTL_AMEN          = 5;
	localparam int             CTL_RX_EN         = 4;
	localparam int             CTL_TX9           = 3;
	localparam int             CTL_RX9           = 2;
	localparam int             CTL_TX_DONE       = 1;
	localparam int             CTL_RX_DONE       = 0;
	localparam int             PWR_BAUD_DBL      = 7;
	localparam int             PWR_FE_SEL        = 6;
	localparam int             IRQ_RX            = 0;
	localparam int             IRQ_TX            = 1;
	localparam int             IRQ_FE            = 2;
	localparam int             IRQ_W             = 3;
	// ======================================================
	// reset values
	localparam logic [7:0]     CTL_RESET         = 8'h00;
	localparam logic [7:0]     PWR_RESET         = 8'h00;
	localparam logic [7:0]     ADDR_RESET        = 8'h00;
	localparam logic [15:0]    BAUD_RESET        = 16'h0364;
	localparam logic [IRQ_W-1:0] IRQ_RESET       = 3'h0;
	// ======================================================
	// bit times in pclk cycles, and the index of the last data bit
	localparam logic [15:0]    MODE0_BIT_CYC     = 16'h000c;
	localparam logic [15:0]    MODE2_BIT_SLOW    = 16'h0040;
	localparam logic [15:0]    MODE2_BIT_FAST    = 16'h0020;
	localparam logic [2:0]     LAST_DATA_BIT     = 3'h7;
	// ======================================================
	// types
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_8BIT  = 2'b01,
		MODE_9FIX  = 2'b10,
		MODE_9VAR  = 2'b11
	} spcu_mode_type;
	typedef enum logic [2:0] {
		FR_IDLE  = 3'b000,
		FR_START = 3'b001,
		FR_DATA  = 3'b010,
		FR_NINTH = 3'b011,
		FR_STOP  = 3'b100
	} spcu_frame_type;
endpackage
`default_nettype wire

// >>> test/spcu_line_model.sv
`default_nettype none
// ======================================================
// far node on the serial line
module spcu_line_model
(
	input  wire logic pclk,
	input  wire logic txd,
	input  wire logic rxd_out,
	input  wire logic rxd_oe,
	output var  logic rxd_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// line idles high between frames, as with a pull-up
	initial rxd_in = 1'b1;

	// start, nb data bits lsb first, then the given stop level
	task automatic send(input logic [8:0] d, input int nb, input logic stp,
		input int bc);
		for (int i = 0; i < nb + 2; i++)
		begin
			@(posedge pclk);
			rxd_in <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i-1];
			repeat (bc - 1) @(posedge pclk);
		end
		@(posedge pclk);
		rxd_in <= 1'b1;
	endtask

	// samples each bit at its middle; hang is cut by the bench watchdog
	task automatic grab(input int nb, input int bc, output logic [8:0] d);
		d = '0;
		@(posedge pclk iff txd === 1'b0);
		repeat (bc / 2) @(posedge pclk);
		for (int i = 0; i < nb; i++)
		begin
			repeat (bc) @(posedge pclk);
			d[i] = txd;
		end
	endtask

	// mode 0: data taken at each rising shift clock; d[8] says oe stood
	task automatic shift_grab(output logic [8:0] d);
		d = 9'h100;
		for (int i = 0; i < 8; i++)
		begin
			@(posedge txd);
			d[i] = rxd_out;
			d[8] = d[8] & rxd_oe;
		end
	endtask

	// mode 0: next bit put out on each falling shift clock
	task automatic shift_send(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge txd);
			rxd_in <= d[i];
		end
		@(posedge txd);
		rxd_in <= 1'b1;
	endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import spcu_pkg::*;

	logic                   pclk, presetn, psel, penable, pwrite;
	logic [SPCU_ADDR_W-1:0] paddr;
	logic [31:0]            pwdata, prdata, rd, seed;
	logic                   pready, pslverr, er, rxd_in, rxd_out;
	logic                   rxd_oe, txd, irq;
	logic [8:0]             g;
	logic [7:0]             b;
	int                     miscompares, checks_done, cnt;
	logic [7:0] tc [5] = '{8'h00, 8'h88, 8'h88, 8'h40, 8'hc8};
	logic [7:0] tp [5] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
	int         bt [5] = '{12, 64, 32, 16, 16};
	int         te [5] = '{96, 640, 320, 144, 160};
	logic [8:0] af [5] = '{9'h1c2, 9'h1c1, 9'h0c2, 9'h1ff, 9'h100};

	spcu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
		.irq(irq));
	spcu_line_model line (.pclk(pclk), .txd(txd), .rxd_out(rxd_out),
		.rxd_oe(rxd_oe), .rxd_in(rxd_in));

	// ======================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// given match under the mask, or broadcast match on own | mask
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o,
		input logic [7:0] m);
		return ((a & m) == (o & m)) || ((a & (o | m)) == (o | m));
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rx(input logic [8:0] d, input int nb, input logic stp);
		line.send(d, nb, stp, 16);
		apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
	endtask

	task automatic wrap_up;
		if (miscompares == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ======================================================
	// clock, reset, watchdog
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial
	begin
		#200000;
		miscompares++;
		wrap_up();
	end

	// ======================================================
	// scenarios
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = '0;
		pwdata = '0;
		miscompares = 0;
		checks_done = 0;
		seed = 32'd89255;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
		chk(rd, {24'h0, CTL_RESET});
		apb(1'b0, SPCU_OFF_BAUD, 32'h0);
		chk(rd, {16'h0, BAUD_RESET});
		apb(1'b0, 8'hfc, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, SPCU_OFF_BAUD, 32'd16);
		apb(1'b1, SPCU_OFF_IRQ_MASK, 32'h2);
		// transmit in modes 0 to 3, amen kept clear in every setting
		for (int i = 0; i < 5; i++)
		begin
			seed = xs(seed);
			apb(1'b1, SPCU_OFF_POWER, {24'h0, tp[i]});
			apb(1'b1, SPCU_OFF_CONTROL, {24'h0, tc[i]});
			apb(1'b1, SPCU_OFF_DATA, {24'h0, seed[7:0]});
			cnt = 0;
			g = '0;
			fork
				if (i > 0)
					line.grab(9, bt[i], g);
				else
					line.shift_grab(g);
				while (irq !== 1'b1)
				begin
					@(posedge pclk);
					cnt++;
				end
			join
			chk(cnt >= te[i] && cnt <= te[i] + 5, 1);
			chk(g, {tc[i][7] ? tc[i][3] : 1'b1, seed[7:0]});
			apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
			chk(rd, {24'h0, tc[i] | 8'h02});
			apb(1'b1, SPCU_OFF_IRQ_MASK, 32'h0);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
			apb(1'b1, SPCU_OFF_IRQ_MASK, 32'h2);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b1);
			apb(1'b1, SPCU_OFF_IRQ_STAT, 32'h7);
			repeat (2) @(posedge pclk);
			chk(irq, 1'b0);
			repeat (bt[i] * 2) @(posedge pclk);
		end
		// mode 0 reception, far node shifts on the block's clock
		seed = xs(seed);
		apb(1'b1, SPCU_OFF_POWER, 32'h0);
		fork
			apb(1'b1, SPCU_OFF_CONTROL, 32'h10);
			line.shift_send(seed[7:0]);
		join
		repeat (24) @(posedge pclk);
		apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
		chk(rd, 32'h11);
		apb(1'b0, SPCU_OFF_DATA, 32'h0);
		chk(rd, {24'h0, seed[7:0]});
		// mode 1 reception, stop bit lands in rx_ninth_bit
		seed = xs(seed);
		apb(1'b1, SPCU_OFF_POWER, 32'h0);
		apb(1'b1, SPCU_OFF_CONTROL, 32'h50);
		rx({1'b0, seed[7:0]}, 8, 1'b1);
		chk(rd, 32'h55);
		apb(1'b0, SPCU_OFF_DATA, 32'h0);
		chk(rd, {24'h0, seed[7:0]});
		apb(1'b1, SPCU_OFF_CONTROL, 32'h40);
		rx(9'h0a5, 8, 1'b1);
		chk(rd, 32'h40);
		// framing error: sticky, hidden behind mode bit when not selected
		apb(1'b1, SPCU_OFF_POWER, 32'h40);
		apb(1'b1, SPCU_OFF_CONTROL, 32'h50);
		rx(9'h03c, 8, 1'b0);
		chk(rd[7], 1'b1);
		rx(9'h03c, 8, 1'b1);
		chk(rd[7], 1'b1);
		apb(1'b0, SPCU_OFF_IRQ_STAT, 32'h0);
		chk(rd[IRQ_FE], 1'b1);
		apb(1'b1, SPCU_OFF_POWER, 32'h0);
		apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
		chk(rd[7], 1'b0);
		apb(1'b1, SPCU_OFF_POWER, 32'h40);
		apb(1'b1, SPCU_OFF_CONTROL, 32'h50);
		apb(1'b0, SPCU_OFF_CONTROL, 32'h0);
		chk(rd[7], 1'b0);
		apb(1'b1, SPCU_OFF_POWER, 32'h0);
		apb(1'b1, SPCU_OFF_IRQ_STAT, 32'h7);
		// address recognition in mode 3
		apb(1'b1, SPCU_OFF_OWN_ADDR, 32'hc0);
		apb(1'b1, SPCU_OFF_ADDR_MSK, 32'hfd);
		for (int i = 0; i < 5; i++)
		begin
			seed = xs(seed);
			b = (i == 4) ? seed[7:0] : af[i][7:0];
			apb(1'b1, SPCU_OFF_CONTROL, 32'hf0);
			rx({af[i][8], b}, 9, 1'b1);
			chk(rd[0], af[i][8] & hit(b, 8'hc0, 8'hfd));
			chk(rd[2], af[i][8] & hit(b, 8'hc0, 8'hfd));
			if (rd[0] === 1'b1)
			begin
				apb(1'b0, SPCU_OFF_DATA, 32'h0);
				chk(rd, {24'h0, b});
			end
		end
		// mode 1 with amen: bad stop bit never raises the receive flag
		apb(1'b1, SPCU_OFF_CONTROL, 32'h70);
		rx(9'h0c0, 8, 1'b0);
		chk(rd[0], 1'b0);
		rx(9'h0c0, 8, 1'b1);
		chk(rd[0], 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
